// ==== design/rtcs_device.sv ====
/*
  Clock-chip slave: serial front end, 64-byte map, clock-copy hold and
  power-fail lockout. Assumes supply comparators arrive as async levels and
  that the serial clock stands still between frames.
*/
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
module rtcs_device
  import rtcs_pkg::*;
#(
  parameter int unsigned REC_CYCLES = REC_CYCLES_DEF
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PWR_ABOVE_PFD,
  input wire logic PWR_ABOVE_SO,
  input wire logic SRAM_ENABLE_IN_N,
  input wire logic IRQ_REQ,
  output logic RST_O,
  output logic RST_OE,
  output logic IRQ_TEST_OUT_N_O,
  output logic IRQ_TEST_OUT_N_OE,
  output logic SRAM_ENABLE_GATED_N,
  output logic SRAM_ENABLE_GATED_OE,
  output logic BATTERY_SEL,
  output logic COPY_HOLD,
  rtcs_link_if.device LINK
);
  // L_RDONE: read closed by a missing acknowledge, pointer still counts for the clock hold
  typedef enum logic [2:0] {
    L_IDLE, L_ADDR, L_PTR, L_WDATA, L_RDATA, L_IGNORE, L_RDONE
  } rtcs_lstate_t;

  logic link_rst_r;
  logic protect_r;
  logic [31:0] rec_cnt_r;
  logic [1:0] pfd_sync_r, so_sync_r, en_sync_r, irq_sync_r;
  logic [1:0] start_sync_r, stop_sync_r, lo_sync_r;
  logic start_seen_r, stop_seen_r, frame_open_r;
  logic start_tgl_r, stop_tgl_r, start_ack_r;
  rtcs_lstate_t st_r, after_ack_r;
  logic [3:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic [5:0] ptr_r;
  logic ack_pend_r;
  logic sda_oe_r;
  logic [7:0] byte_in;
  logic [7:0] tx_byte;
  logic new_frame;
  logic byte_done;
  logic wr_en;
  logic ptr_in_clock;
  logic [7:0] mem [MAP_BYTES] = '{default: 8'h00};

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: supply monitoring and recovery
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pfd_sync_r <= 2'h0;
      so_sync_r <= 2'h0;
      en_sync_r <= 2'h3;
      irq_sync_r <= 2'h0;
    end else begin
      pfd_sync_r <= {pfd_sync_r[0], PWR_ABOVE_PFD};
      so_sync_r <= {so_sync_r[0], PWR_ABOVE_SO};
      en_sync_r <= {en_sync_r[0], SRAM_ENABLE_IN_N};
      irq_sync_r <= {irq_sync_r[0], IRQ_REQ};
    end
  end

  // Counter restarts on every dip, so a glitchy supply never shortens recovery
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rec_cnt_r <= 32'h0;
      protect_r <= 1'b1;
    end else if (!pfd_sync_r[1]) begin
      rec_cnt_r <= 32'h0;
      protect_r <= 1'b1;
    end else if (rec_cnt_r != REC_CYCLES) begin
      rec_cnt_r <= rec_cnt_r + 32'h1;
      protect_r <= 1'b1;
    end else begin
      protect_r <= 1'b0;
    end
  end

  // Link logic is held in reset while protected: aborts frames, clears pointer
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      link_rst_r <= 1'b1;
    end else begin
      link_rst_r <= protect_r;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RST_OE <= 1'b0;
      IRQ_TEST_OUT_N_OE <= 1'b0;
      SRAM_ENABLE_GATED_N <= 1'b1;
      SRAM_ENABLE_GATED_OE <= 1'b0;
      BATTERY_SEL <= 1'b1;
    end else begin
      RST_OE <= protect_r && so_sync_r[1];
      IRQ_TEST_OUT_N_OE <= irq_sync_r[1] && so_sync_r[1];
      SRAM_ENABLE_GATED_N <= protect_r ? 1'b1 : en_sync_r[1];
      SRAM_ENABLE_GATED_OE <= so_sync_r[1];
      BATTERY_SEL <= !so_sync_r[1];
    end
  end

  assign RST_O = 1'b0;
  assign IRQ_TEST_OUT_N_O = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: clock-copy hold follows frame and pointer range
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      start_sync_r <= 2'h0;
      stop_sync_r <= 2'h0;
      lo_sync_r <= 2'h0;
      start_seen_r <= 1'b0;
      stop_seen_r <= 1'b0;
      frame_open_r <= 1'b0;
      COPY_HOLD <= 1'b0;
    end else begin
      start_sync_r <= {start_sync_r[0], start_tgl_r};
      stop_sync_r <= {stop_sync_r[0], stop_tgl_r};
      lo_sync_r <= {lo_sync_r[0], ptr_in_clock};
      start_seen_r <= start_sync_r[1];
      stop_seen_r <= stop_sync_r[1];
      if (stop_sync_r[1] != stop_seen_r || link_rst_r) begin
        frame_open_r <= 1'b0;
      end else if (start_sync_r[1] != start_seen_r) begin
        frame_open_r <= 1'b1;
      end
      COPY_HOLD <= frame_open_r && lo_sync_r[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line-condition detectors, clocked by the data line itself
  always_ff @(negedge LINK.sda or posedge link_rst_r) begin
    if (link_rst_r) begin
      start_tgl_r <= 1'b0;
    end else if (LINK.scl) begin
      start_tgl_r <= !start_tgl_r;
    end
  end

  always_ff @(posedge LINK.sda or posedge link_rst_r) begin
    if (link_rst_r) begin
      stop_tgl_r <= 1'b0;
    end else if (LINK.scl) begin
      stop_tgl_r <= !stop_tgl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: bits sampled on the rising serial clock
  assign new_frame = (start_tgl_r != start_ack_r);
  assign byte_in = {shift_r, LINK.sda};
  assign byte_done = !new_frame && (bit_cnt_r == BYTE_BITS - 4'h1);
  assign tx_byte = mem[ptr_r];
  // Hold stays up after a final read until STOP while the pointer is still in range
  assign ptr_in_clock = (st_r == L_WDATA || st_r == L_RDATA || st_r == L_RDONE)
                        && (ptr_r <= CLOCK_LAST);
  // Reserved locations keep reading zero
  assign wr_en = !link_rst_r && byte_done && (st_r == L_WDATA)
                 && !(ptr_r >= RESV_FIRST && ptr_r <= RESV_LAST);

  always_ff @(posedge LINK.scl or posedge link_rst_r) begin
    if (link_rst_r) begin
      st_r <= L_IDLE;
      after_ack_r <= L_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 7'h00;
      ptr_r <= 6'h00;
      ack_pend_r <= 1'b0;
      start_ack_r <= 1'b0;
    end else if (new_frame) begin
      start_ack_r <= start_tgl_r;
      st_r <= L_ADDR;
      shift_r <= {6'h00, LINK.sda};
      bit_cnt_r <= 4'h1;
      ack_pend_r <= 1'b0;
    end else if (st_r != L_IDLE && st_r != L_IGNORE && st_r != L_RDONE) begin
      if (bit_cnt_r == ACK_BIT) begin
        bit_cnt_r <= 4'h0;
        ack_pend_r <= 1'b0;
        if (st_r == L_WDATA || st_r == L_RDATA) begin
          ptr_r <= ptr_r + 6'h01;
        end
        if (st_r == L_RDATA) begin
          st_r <= LINK.sda ? L_RDONE : L_RDATA;
        end else begin
          st_r <= after_ack_r;
        end
      end else begin
        shift_r <= byte_in[6:0];
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (bit_cnt_r == BYTE_BITS - 4'h1) begin
          case (st_r)
            L_ADDR: begin
              if (byte_in[7:1] == SLAVE_ADDR) begin
                ack_pend_r <= 1'b1;
                after_ack_r <= byte_in[0] ? L_RDATA : L_PTR;
              end else begin
                st_r <= L_IGNORE;
              end
            end
            L_PTR: begin
              ptr_r <= byte_in[5:0];
              ack_pend_r <= 1'b1;
              after_ack_r <= L_WDATA;
            end
            L_WDATA: begin
              ack_pend_r <= 1'b1;
              after_ack_r <= L_WDATA;
            end
            default: begin
              ack_pend_r <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge LINK.scl) begin
    if (wr_en) begin
      mem[ptr_r] <= byte_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: data line driven on the falling serial clock
  always_ff @(negedge LINK.scl or posedge link_rst_r) begin
    if (link_rst_r) begin
      sda_oe_r <= 1'b0;
    end else if (bit_cnt_r == ACK_BIT && ack_pend_r) begin
      sda_oe_r <= 1'b1;
    end else if (st_r == L_RDATA && bit_cnt_r < BYTE_BITS) begin
      sda_oe_r <= !tx_byte[3'(4'h7 - bit_cnt_r)];
    end else begin
      sda_oe_r <= 1'b0;
    end
  end

  assign LINK.s_sda_o = 1'b0;
  assign LINK.s_sda_oe = sda_oe_r;
endmodule

// ==== design/rtcs_link_if.sv ====
/*
  Two-wire link between the bus master and the clock-chip slave.
  Both data drivers are open drain; the wire level is resolved here.
*/
`timescale 1ns/10ps
interface rtcs_link_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Pull-up wins unless a driver enables a low
  assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
  assign sda = ((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o)) ? 1'b0 : 1'b1;
  modport master (output scl_o, output scl_oe, output m_sda_o, output m_sda_oe,
                  input scl, input sda);
  modport device (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

// ==== design/rtcs_master.sv ====
/*
  Two-wire bus master: runs one command at a time (START, byte write,
  byte read with or without acknowledge, STOP) and makes the serial clock
  by dividing its core clock into quarter phases.
*/
`timescale 1ns/10ps
module rtcs_master
  import rtcs_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire rtcs_cmd_t CMD_KIND,
  input wire logic [7:0] CMD_DATA,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_ACK,
  rtcs_link_if.master LINK
);
  typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} rtcs_mstate_t;

  rtcs_mstate_t st_r;
  rtcs_cmd_t kind_r;
  logic [3:0] div_r;
  logic [1:0] qtr_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic [1:0] sda_sync_r;
  logic scl_r, sda_oe_r;
  logic tick;

  assign tick = (div_r == QTR_CYCLES - 4'h1);
  assign CMD_READY = (st_r == M_IDLE);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sda_sync_r <= 2'h3;
    end else begin
      sda_sync_r <= {sda_sync_r[0], LINK.sda};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || st_r == M_IDLE || tick) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-phase sequencer
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st_r <= M_IDLE;
      kind_r <= RTCS_CMD_STOP;
      qtr_r <= 2'h0;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      scl_r <= 1'b1;
      sda_oe_r <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_DATA <= 8'h00;
      RSP_ACK <= 1'b0;
    end else begin
      RSP_VALID <= 1'b0;
      unique case (st_r)
        M_IDLE: begin
          qtr_r <= 2'h0;
          bit_r <= 4'h0;
          if (CMD_VALID) begin
            kind_r <= CMD_KIND;
            shift_r <= CMD_DATA;
            unique case (CMD_KIND)
              RTCS_CMD_START: st_r <= M_START;
              RTCS_CMD_STOP: st_r <= M_STOP;
              default: st_r <= M_BYTE;
            endcase
          end
        end
        M_START: if (tick) begin
          qtr_r <= qtr_r + 2'h1;
          unique case (qtr_r)
            2'h0: sda_oe_r <= 1'b0;
            2'h1: scl_r <= 1'b1;
            2'h2: sda_oe_r <= 1'b1;
            2'h3: begin
              scl_r <= 1'b0;
              st_r <= M_IDLE;
            end
          endcase
        end
        M_STOP: if (tick) begin
          qtr_r <= qtr_r + 2'h1;
          unique case (qtr_r)
            2'h0: sda_oe_r <= 1'b1;
            2'h1: scl_r <= 1'b1;
            2'h2: sda_oe_r <= 1'b0;
            2'h3: st_r <= M_IDLE;
          endcase
        end
        M_BYTE: if (tick) begin
          qtr_r <= qtr_r + 2'h1;
          unique case (qtr_r)
            2'h0: begin
              // Data bits move in the clock-low quarter; the acknowledge drive is released with the falling clock
              if (bit_r < BYTE_BITS) begin
                sda_oe_r <= (kind_r == RTCS_CMD_WRITE) && !shift_r[7];
              end else begin
                sda_oe_r <= (kind_r == RTCS_CMD_READ_ACK);
              end
            end
            2'h1: scl_r <= 1'b1;
            2'h2: begin
              if (bit_r < BYTE_BITS) begin
                shift_r <= {shift_r[6:0], sda_sync_r[1]};
              end else begin
                RSP_ACK <= !sda_sync_r[1];
              end
            end
            2'h3: begin
              scl_r <= 1'b0;
              bit_r <= bit_r + 4'h1;
              if (bit_r == ACK_BIT) begin
                sda_oe_r <= 1'b0;
                RSP_DATA <= shift_r;
                RSP_VALID <= 1'b1;
                st_r <= M_IDLE;
              end
            end
          endcase
        end
      endcase
    end
  end

  assign LINK.scl_o = scl_r;
  assign LINK.scl_oe = 1'b1;
  assign LINK.m_sda_o = 1'b0;
  assign LINK.m_sda_oe = sda_oe_r;
endmodule

// ==== design/rtcs_pkg.sv ====
/*
  Shared constants for the serial clock-chip slave and its bus master.
  Assumes a 100 MHz core clock on both ends and a master-made serial clock.
*/
package rtcs_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h68;
  localparam int unsigned MAP_BYTES = 64;
  localparam logic [5:0] CLOCK_FIRST = 6'h00;
  localparam logic [5:0] CLOCK_LAST = 6'h07;
  localparam logic [5:0] CONTROL_ADDR = 6'h08;
  localparam logic [5:0] WATCHDOG_ADDR = 6'h09;
  localparam logic [5:0] ALARM_FIRST = 6'h0A;
  localparam logic [5:0] RESV_FIRST = 6'h10;
  localparam logic [5:0] RESV_LAST = 6'h12;
  localparam logic [5:0] SQWAVE_ADDR = 6'h13;
  localparam logic [5:0] USER_FIRST = 6'h14;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam int unsigned CORE_CLK_MHZ = 100;
  localparam int unsigned REC_INTERVAL_US = 1000;
  localparam int unsigned REC_CYCLES_DEF = REC_INTERVAL_US * CORE_CLK_MHZ;
  localparam logic [3:0] QTR_CYCLES = 4'h5;
  typedef enum logic [2:0] {
    RTCS_CMD_START,
    RTCS_CMD_WRITE,
    RTCS_CMD_READ_ACK,
    RTCS_CMD_READ_NACK,
    RTCS_CMD_STOP
  } rtcs_cmd_t;
endpackage

// ==== testbench/rtcs_checker.sv ====
/*
  Link checker: judges the resolved two-wire signals on the core clock.
  Assumes instantiation beside the link interface, master-made serial clock.
*/
`timescale 1ns/10ps
module rtcs_checker
  import rtcs_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic scl_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic scl_d_r, sda_d_r, in_frame_r, first_r, rd_r, foreign_r, nack_r;
  logic [3:0] bit_r;
  logic [6:0] sh_r;
  wire logic start_w = scl && scl_d_r && sda_d_r && !sda;
  wire logic stop_w = scl && scl_d_r && !sda_d_r && sda;
  wire logic rise_w = scl && !scl_d_r;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end
  // Frame state rebuilt from the wires only, so a design slip is not inherited
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || stop_w) begin
      in_frame_r <= 1'b0;
      rd_r <= 1'b0;
      foreign_r <= 1'b0;
      nack_r <= 1'b0;
    end else if (start_w) begin
      in_frame_r <= 1'b1;
      first_r <= 1'b1;
      bit_r <= 4'h0;
      rd_r <= 1'b0;
      foreign_r <= 1'b0;
      nack_r <= 1'b0;
    end else if (rise_w && in_frame_r) begin
      sh_r <= {sh_r[5:0], sda};
      bit_r <= (bit_r == ACK_BIT) ? 4'h0 : bit_r + 4'h1;
      if (bit_r == ACK_BIT) begin
        first_r <= 1'b0;
      end
      if (bit_r == ACK_BIT && rd_r && !first_r && sda) begin
        nack_r <= 1'b1;
      end
      if (first_r && bit_r == 4'h7) begin
        foreign_r <= (sh_r != SLAVE_ADDR);
        rd_r <= sda;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_dev_steady_high: assert property (scl && scl_d_r |-> $stable(s_sda_oe))
    else $error("slave data changed while clock high");
  a_dev_pull_low: assert property (rise_w && s_sda_oe
    |-> (s_sda_oe && !s_sda_o) [*8])
    else $error("slave low not held through clock high");
  a_foreign_quiet: assert property (foreign_r |-> !s_sda_oe)
    else $error("slave drives in foreign frame");
  a_write_data_quiet: assert property (rise_w && in_frame_r && !rd_r && bit_r != ACK_BIT
    |-> !s_sda_oe)
    else $error("slave drives data bit of a write");
  a_read_ack_master: assert property (rise_w && rd_r && !first_r && bit_r == ACK_BIT
    |-> !s_sda_oe)
    else $error("slave drives master acknowledge slot");
  a_nack_release: assert property (nack_r |-> !s_sda_oe)
    else $error("slave drives after missing acknowledge");
  a_idle_quiet: assert property (!in_frame_r |-> !s_sda_oe)
    else $error("slave drives outside a frame");
  a_idle_lines: assert property (!in_frame_r |-> scl && scl_oe)
    else $error("clock not high on idle bus");
  a_start_clock_low: assert property (start_w |-> ##[1:10] !scl)
    else $error("clock not lowered after start");
  a_bit_pulse: assert property (rise_w |-> scl [*8])
    else $error("clock high phase too short");
endmodule

// ==== testbench/tb_i2c_rtc_slave_access_powerfail.sv ====
/*
  Bench top: master and slave joined by the link interface, driven through
  the master command port and supply inputs. Assumes package compiled first.
*/
`timescale 1ns/10ps
module tb_i2c_rtc_slave_access_powerfail
  import rtcs_pkg::*;
;
  // Short recovery count keeps the run brief
  localparam int unsigned REC = 50;
  logic core_clk, rst_n, pfd, so, sram_in_n, irq_req, cmd_valid, cmd_ready, rsp_valid;
  logic rst_o, rst_oe, irq_o, irq_oe, sram_n, sram_oe, bat_sel, hold, rsp_ack;
  rtcs_cmd_t cmd_kind;
  logic [7:0] cmd_data, rsp_data;
  int fail_count = 0;
  int total_checks = 0;
  rtcs_link_if link ();
  rtcs_device #(.REC_CYCLES(REC)) u_rtcs_device (.CORE_CLK(core_clk), .RST_N(rst_n),
    .PWR_ABOVE_PFD(pfd), .PWR_ABOVE_SO(so), .SRAM_ENABLE_IN_N(sram_in_n), .IRQ_REQ(irq_req),
    .RST_O(rst_o), .RST_OE(rst_oe), .IRQ_TEST_OUT_N_O(irq_o), .IRQ_TEST_OUT_N_OE(irq_oe),
    .SRAM_ENABLE_GATED_N(sram_n), .SRAM_ENABLE_GATED_OE(sram_oe), .BATTERY_SEL(bat_sel),
    .COPY_HOLD(hold), .LINK(link));
  rtcs_master u_rtcs_master (.CORE_CLK(core_clk), .RST_N(rst_n), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_KIND(cmd_kind), .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .RSP_ACK(rsp_ack), .LINK(link));
  rtcs_checker u_rtcs_checker (.CORE_CLK(core_clk), .RST_N(rst_n), .scl_oe(link.scl_oe),
    .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic exp, input logic act);
    total_checks++;
    if (act !== exp) begin
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
      fail_count++;
    end
  endtask
  task automatic chk_byte(input logic [7:0] exp, input logic [7:0] act);
    total_checks++;
    if (act !== exp) begin
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
      fail_count++;
    end
  endtask
  // Checks land mid-cycle so clocked outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic cmd(input rtcs_cmd_t k, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_data <= d;
    do begin
      @(negedge core_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 2000);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (((k == RTCS_CMD_START || k == RTCS_CMD_STOP) ? cmd_ready : rsp_valid) !== 1'b1
      && n < 2000);
    if (n >= 2000) begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic wb(input logic [7:0] d, input logic ack);
    cmd(RTCS_CMD_WRITE, d);
    chk_bit(ack, rsp_ack);
  endtask
  task automatic rb(input rtcs_cmd_t k, input logic [7:0] exp);
    cmd(k, 8'h00);
    chk_byte(exp, rsp_data);
  endtask
  task automatic wr_at(input logic [7:0] p, input logic [7:0] a, input logic [7:0] b);
    cmd(RTCS_CMD_START, 8'h00);
    wb(8'hD0, 1'b1);
    wb(p, 1'b1);
    wb(a, 1'b1);
    wb(b, 1'b1);
  endtask
  task automatic rd_at(input logic [7:0] p, input logic [7:0] a, input logic [7:0] b);
    cmd(RTCS_CMD_START, 8'h00);
    wb(8'hD0, 1'b1);
    wb(p, 1'b1);
    cmd(RTCS_CMD_START, 8'h00);
    wb(8'hD1, 1'b1);
    rb(RTCS_CMD_READ_ACK, a);
    rb(RTCS_CMD_READ_NACK, b);
  endtask
  task automatic wait_rec();
    int n;
    n = 0;
    while (rst_oe !== 1'b0 && n < 400) begin
      cyc(0);
      n++;
    end
    if (n >= 400) begin
      fail_count++;
      conclude();
    end
    cyc(4);
    chk_bit(1'b0, sram_n);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_write_seq();
    cmd(RTCS_CMD_START, 8'h00);
    wb(8'hD0, 1'b1);
    wb(8'h06, 1'b1);
    wb(8'hA1, 1'b1);
    cyc(8);
    chk_bit(1'b1, hold);
    wb(8'hA2, 1'b1);
    cyc(8);
    chk_bit(1'b0, hold);
    wb(8'hA3, 1'b1);
    cmd(RTCS_CMD_STOP, 8'h00);
  endtask
  task automatic t_read_seq();
    rd_at(8'h05, 8'h00, 8'hA1);
    cyc(8);
    chk_bit(1'b1, hold);
    cmd(RTCS_CMD_STOP, 8'h00);
    cyc(8);
    chk_bit(1'b0, hold);
    cmd(RTCS_CMD_START, 8'h00);
    wb(8'hD1, 1'b1);
    rb(RTCS_CMD_READ_ACK, 8'hA2);
    rb(RTCS_CMD_READ_NACK, 8'hA3);
    cmd(RTCS_CMD_STOP, 8'h00);
  endtask
  task automatic t_map();
    wr_at(8'h3F, 8'h5A, 8'h6B);
    wr_at(8'h0F, 8'hC3, 8'hFF);
    rd_at(8'h3F, 8'h5A, 8'h6B);
    rd_at(8'h0F, 8'hC3, 8'h00);
    cmd(RTCS_CMD_STOP, 8'h00);
  endtask
  task automatic t_foreign();
    cmd(RTCS_CMD_START, 8'h00);
    wb(8'hD2, 1'b0);
    wb(8'h55, 1'b0);
    cmd(RTCS_CMD_START, 8'h00);
    wb(8'hA0, 1'b0);
    cmd(RTCS_CMD_STOP, 8'h00);
  endtask
  task automatic t_power();
    @(posedge core_clk);
    sram_in_n <= 1'b1;
    irq_req <= 1'b1;
    cyc(4);
    chk_bit(1'b1, sram_n);
    chk_bit(1'b1, irq_oe);
    chk_bit(1'b0, irq_o);
    @(posedge core_clk);
    sram_in_n <= 1'b0;
    wr_at(8'h1E, 8'h77, 8'h11);
    @(posedge core_clk);
    pfd <= 1'b0;
    cyc(6);
    chk_bit(1'b1, rst_oe);
    chk_bit(1'b0, rst_o);
    chk_bit(1'b1, sram_n);
    wb(8'h22, 1'b0);
    cmd(RTCS_CMD_STOP, 8'h00);
    @(posedge core_clk);
    so <= 1'b0;
    cyc(6);
    chk_bit(1'b1, bat_sel);
    chk_bit(1'b0, sram_oe);
    chk_bit(1'b0, irq_oe);
    chk_bit(1'b0, rst_oe);
    @(posedge core_clk);
    so <= 1'b1;
    pfd <= 1'b1;
    irq_req <= 1'b0;
    cyc(REC - 10);
    chk_bit(1'b1, sram_n);
    chk_bit(1'b1, rst_oe);
    wait_rec();
    chk_bit(1'b0, bat_sel);
    cmd(RTCS_CMD_START, 8'h00);
    wb(8'hD1, 1'b1);
    rb(RTCS_CMD_READ_NACK, 8'h6B);
    rd_at(8'h1F, 8'h11, 8'h00);
    cmd(RTCS_CMD_STOP, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    pfd = 1'b1;
    so = 1'b1;
    sram_in_n = 1'b0;
    irq_req = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = RTCS_CMD_START;
    cmd_data = 8'h00;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(10);
    chk_bit(1'b1, rst_oe);
    chk_bit(1'b1, sram_n);
    wait_rec();
    t_write_seq();
    t_read_seq();
    t_map();
    t_foreign();
    t_power();
    conclude();
  end
endmodule
